// file: shared/png_pkg.sv
// constants and types shared by the playback noise gate
package png_pkg;
   // clock and ramp timing, times in ns
   localparam int PNG_CLK_NS = 40;
   localparam int PNG_FALL_FAST_NS = 880_000;
   localparam int PNG_FALL_SLOW_NS = 14_080_000;
   localparam int PNG_RISE_SLOW_NS = 220_000;
   localparam int PNG_RISE_FAST_NS = 13_800;
   localparam int PNG_TICK_W = 24;

   // sample path
   localparam int PNG_DW = 24;
   localparam int PNG_FRAC_SH = 15;
   localparam int PNG_ATTEN_W = 7;
   localparam logic [PNG_ATTEN_W-1:0] PNG_ATTEN_MAX = 7'h78;
   localparam logic [PNG_ATTEN_W-1:0] PNG_DB_PER_SHIFT = 7'h06;
   localparam int PNG_HOLD_W = 12;
   localparam logic [PNG_HOLD_W-1:0] PNG_HOLD_BASE = 12'h100;
   localparam logic [1:0] PNG_BUF_FULL = 2'h2;

   // 1 dB gain steps within one 6 dB octave, q1.15
   localparam logic [5:0][15:0] PNG_FRAC_TAB = {
      16'h47FB, 16'h50C3, 16'h5A9D, 16'h65AD, 16'h7214, 16'h8000};
   // full-scale-relative levels for codes 0..7 (-102 dB .. -60 dB)
   localparam logic [7:0][PNG_DW-1:0] PNG_THR_TAB = {
      24'h00_20C5, 24'h00_106C, 24'h00_083B, 24'h00_0420,
      24'h00_0211, 24'h00_0109, 24'h00_0085, 24'h00_0043};

   // register bus
   localparam int PNG_AW = 12;
   localparam logic [7:0] PNG_IDX_CTRL = 8'h9C;
   localparam logic [7:0] PNG_IDX_TIMING = 8'h9D;
   localparam logic [7:0] PNG_IDX_RELEASE = 8'h9E;
   localparam logic [7:0] PNG_IDX_ENGAGE = 8'h9F;
   localparam logic [7:0] PNG_IDX_STATUS = 8'hA0;
   localparam logic [PNG_AW-1:0] PNG_ADDR_CTRL = {2'h0, PNG_IDX_CTRL, 2'h0};
   localparam logic [PNG_AW-1:0] PNG_ADDR_TIMING = {2'h0, PNG_IDX_TIMING, 2'h0};
   localparam logic [PNG_AW-1:0] PNG_ADDR_RELEASE = {2'h0, PNG_IDX_RELEASE, 2'h0};
   localparam logic [PNG_AW-1:0] PNG_ADDR_ENGAGE = {2'h0, PNG_IDX_ENGAGE, 2'h0};
   localparam logic [PNG_AW-1:0] PNG_ADDR_STATUS = {2'h0, PNG_IDX_STATUS, 2'h0};
   localparam logic [1:0] PNG_RESP_OKAY = 2'h0;
   localparam logic [1:0] PNG_RESP_SLVERR = 2'h2;

   // field positions
   localparam int PNG_EN_BIT = 7;
   localparam int PNG_FALL_BIT = 3;
   localparam int PNG_RISE_BIT = 2;
   localparam int PNG_HOLD_LSB = 0;
   localparam int PNG_CODE_LSB = 0;
   localparam int PNG_ST_LSB = 8;
   localparam int PNG_ATTEN_LSB = 0;

   typedef enum logic [1:0] {
      GATE_OPEN,
      GATE_CLOSING,
      GATE_SHUT,
      GATE_OPENING
   } png_gate_st_t;
endpackage

// file: rtl/png_noise_gate.sv
// playback noise gate with axi4-lite registers and a two-entry output buffer
//
// Functional notes
// - gate acts only while enable bit is one; otherwise samples pass unchanged
// - mute after 256/512/1024/2048 quiet samples below engage level
// - engage level code 0..7 maps -102 dB to -60 dB, 6 dB steps
// - release level has its own code; louder signal than it lifts the gate
// - ramp down 0.88 or 14.08 ms per dB, by the fall select bit
// - ramp up 0.22 or 0.0138 ms per dB, by the rise select bit
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module png_noise_gate import png_pkg::*; #(
   parameter int FALL_FAST_CYC = (PNG_FALL_FAST_NS + PNG_CLK_NS - 1) / PNG_CLK_NS,
   parameter int FALL_SLOW_CYC = (PNG_FALL_SLOW_NS + PNG_CLK_NS - 1) / PNG_CLK_NS,
   parameter int RISE_SLOW_CYC = (PNG_RISE_SLOW_NS + PNG_CLK_NS - 1) / PNG_CLK_NS
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // axi4-lite write address and data
   input wire logic [PNG_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [PNG_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // playback samples in
   input wire logic [PNG_DW-1:0] in_left,
   input wire logic [PNG_DW-1:0] in_right,
   input wire logic in_valid,
   output logic in_ready,
   // gated samples out
   output logic [PNG_DW-1:0] out_left,
   output logic [PNG_DW-1:0] out_right,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int RISE_FAST_CYC = (PNG_RISE_FAST_NS + PNG_CLK_NS - 1) / PNG_CLK_NS;

   typedef enum logic [2:0] {
      REG_CTRL,
      REG_TIMING,
      REG_RELEASE,
      REG_ENGAGE,
      REG_STATUS,
      REG_NONE
   } png_reg_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_got;
      logic w_got;
      logic [PNG_AW-1:0] waddr;
      logic [7:0] wbyte;
      logic wlane0;
      logic quiet_gate_enable;
      logic gate_fall_rate_sel;
      logic gate_rise_rate_sel;
      logic [1:0] gate_hold_count_sel;
      logic [2:0] gate_release_code;
      logic [2:0] gate_engage_code;
      png_gate_st_t st;
      logic [PNG_ATTEN_W-1:0] atten;
      logic [PNG_TICK_W-1:0] tick;
      logic [PNG_HOLD_W-1:0] quiet;
      logic [1:0][PNG_DW-1:0] buf_l;
      logic [1:0][PNG_DW-1:0] buf_r;
      logic [1:0] cnt;
      logic in_rdy;
      logic out_vld;
   } png_state_t;

   png_state_t r;
   png_state_t n;

   // magnitude of a two's complement sample; full negative scale still fits unsigned
   function automatic logic [PNG_DW-1:0] png_mag(input logic [PNG_DW-1:0] x);
      return x[PNG_DW-1] ? (~x + 1'b1) : x;
   endfunction

   function automatic logic [PNG_DW-1:0] png_thr(input logic [2:0] code);
      return PNG_THR_TAB[code];
   endfunction

   // one decode for reads and writes, so the two maps cannot drift apart
   function automatic png_reg_t png_decode(input logic [PNG_AW-1:0] addr);
      png_reg_t sel;
      case (addr)
         PNG_ADDR_CTRL: begin
            sel = REG_CTRL;
         end
         PNG_ADDR_TIMING: begin
            sel = REG_TIMING;
         end
         PNG_ADDR_RELEASE: begin
            sel = REG_RELEASE;
         end
         PNG_ADDR_ENGAGE: begin
            sel = REG_ENGAGE;
         end
         PNG_ADDR_STATUS: begin
            sel = REG_STATUS;
         end
         default: begin
            sel = REG_NONE;
         end
      endcase
      return sel;
   endfunction

   // attenuation in whole dB: shift per 6 dB plus a table for the remainder
   function automatic logic [PNG_DW-1:0] png_gain(input logic [PNG_DW-1:0] x,
                                                  input logic [PNG_ATTEN_W-1:0] att);
      logic signed [PNG_DW+16:0] prod;
      logic signed [PNG_DW-1:0] y;
      logic [PNG_ATTEN_W-1:0] whole;
      logic [PNG_ATTEN_W-1:0] rem;
      whole = att / PNG_DB_PER_SHIFT;
      rem = att % PNG_DB_PER_SHIFT;
      prod = $signed(x) * $signed({1'b0, PNG_FRAC_TAB[rem[2:0]]});
      y = prod[PNG_FRAC_SH +: PNG_DW];
      y = y >>> whole;
      return (att >= PNG_ATTEN_MAX) ? '0 : y;
   endfunction

   logic s_fire;
   logic m_fire;
   logic [PNG_DW-1:0] mag_l;
   logic [PNG_DW-1:0] mag_r;
   logic [PNG_DW-1:0] level;
   logic [PNG_DW-1:0] gated_l;
   logic [PNG_DW-1:0] gated_r;
   logic [PNG_HOLD_W-1:0] hold_n;
   logic [PNG_TICK_W-1:0] fall_lim;
   logic [PNG_TICK_W-1:0] rise_lim;

   always_comb begin
      n = r;
      s_fire = in_valid && r.in_rdy;
      m_fire = r.out_vld && out_ready;
      mag_l = png_mag(in_left);
      mag_r = png_mag(in_right);
      level = (mag_l > mag_r) ? mag_l : mag_r;
      hold_n = PNG_HOLD_BASE << r.gate_hold_count_sel;
      fall_lim = r.gate_fall_rate_sel ? PNG_TICK_W'(FALL_SLOW_CYC - 1) :
                                        PNG_TICK_W'(FALL_FAST_CYC - 1);
      rise_lim = r.gate_rise_rate_sel ? PNG_TICK_W'(RISE_FAST_CYC - 1) :
                                        PNG_TICK_W'(RISE_SLOW_CYC - 1);
      gated_l = r.quiet_gate_enable ? png_gain(in_left, r.atten) : in_left;
      gated_r = r.quiet_gate_enable ? png_gain(in_right, r.atten) : in_right;

      // register writes: address and data may come in either order
      if (s_axi_awvalid && r.awready) begin
         n.aw_got = 1'b1;
         n.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_got = 1'b1;
         n.wbyte = s_axi_wdata[7:0];
         n.wlane0 = s_axi_wstrb[0];
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (n.aw_got && n.w_got && !n.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = PNG_RESP_OKAY;
         case (png_decode(n.waddr))
            REG_CTRL: begin
               if (n.wlane0) begin
                  n.quiet_gate_enable = n.wbyte[PNG_EN_BIT];
               end
            end
            REG_TIMING: begin
               if (n.wlane0) begin
                  n.gate_fall_rate_sel = n.wbyte[PNG_FALL_BIT];
                  n.gate_rise_rate_sel = n.wbyte[PNG_RISE_BIT];
                  n.gate_hold_count_sel = n.wbyte[PNG_HOLD_LSB +: 2];
               end
            end
            REG_RELEASE: begin
               if (n.wlane0) begin
                  n.gate_release_code = n.wbyte[PNG_CODE_LSB +: 3];
               end
            end
            REG_ENGAGE: begin
               if (n.wlane0) begin
                  n.gate_engage_code = n.wbyte[PNG_CODE_LSB +: 3];
               end
            end
            REG_STATUS: begin
               n.bresp = PNG_RESP_OKAY;
            end
            default: begin
               n.bresp = PNG_RESP_SLVERR;
            end
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      // register reads
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp = PNG_RESP_OKAY;
         n.rdata = '0;
         case (png_decode(s_axi_araddr))
            REG_CTRL: begin
               n.rdata[PNG_EN_BIT] = r.quiet_gate_enable;
            end
            REG_TIMING: begin
               n.rdata[PNG_FALL_BIT] = r.gate_fall_rate_sel;
               n.rdata[PNG_RISE_BIT] = r.gate_rise_rate_sel;
               n.rdata[PNG_HOLD_LSB +: 2] = r.gate_hold_count_sel;
            end
            REG_RELEASE: begin
               n.rdata[PNG_CODE_LSB +: 3] = r.gate_release_code;
            end
            REG_ENGAGE: begin
               n.rdata[PNG_CODE_LSB +: 3] = r.gate_engage_code;
            end
            REG_STATUS: begin
               n.rdata[PNG_ATTEN_LSB +: PNG_ATTEN_W] = r.atten;
               n.rdata[PNG_ST_LSB +: 2] = r.st;
            end
            default: begin
               n.rresp = PNG_RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;

      // gain ramp and gate decision
      if (!r.quiet_gate_enable) begin
         n.st = GATE_OPEN;
         n.atten = '0;
         n.tick = '0;
         n.quiet = '0;
      end else begin
         case (r.st)
            GATE_CLOSING: begin
               if (r.tick >= fall_lim) begin
                  n.tick = '0;
                  n.atten = r.atten + 1'b1;
                  if (n.atten >= PNG_ATTEN_MAX) begin
                     n.st = GATE_SHUT;
                  end
               end else begin
                  n.tick = r.tick + 1'b1;
               end
            end
            GATE_OPENING: begin
               if (r.tick >= rise_lim) begin
                  n.tick = '0;
                  n.atten = r.atten - 1'b1;
                  if (n.atten == '0) begin
                     n.st = GATE_OPEN;
                  end
               end else begin
                  n.tick = r.tick + 1'b1;
               end
            end
            default: begin
               n.tick = '0;
            end
         endcase
         if (s_fire) begin
            if (level >= png_thr(r.gate_engage_code)) begin
               n.quiet = '0;
            end else if (r.quiet < hold_n) begin
               n.quiet = r.quiet + 1'b1;
            end
            if (level > png_thr(r.gate_release_code) &&
                (n.st == GATE_CLOSING || n.st == GATE_SHUT)) begin
               n.st = GATE_OPENING;
               n.tick = '0;
               n.quiet = '0;
            end else if (n.quiet >= hold_n &&
                         (n.st == GATE_OPEN || n.st == GATE_OPENING)) begin
               n.st = GATE_CLOSING;
               n.tick = '0;
            end
         end
      end

      // two-entry buffer; entry 0 always drives the output
      if (m_fire) begin
         n.buf_l[0] = r.buf_l[1];
         n.buf_r[0] = r.buf_r[1];
         n.cnt = r.cnt - 1'b1;
      end
      if (s_fire) begin
         n.buf_l[n.cnt[0]] = gated_l;
         n.buf_r[n.cnt[0]] = gated_r;
         n.cnt = n.cnt + 1'b1;
      end
      n.out_vld = (n.cnt != '0);
      // ready is registered, so a full buffer still refuses the source in the cycle in which a word leaves
      n.in_rdy = (n.cnt != PNG_BUF_FULL);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
   assign in_ready = r.in_rdy;
   assign out_left = r.buf_l[0];
   assign out_right = r.buf_r[0];
   assign out_valid = r.out_vld;

endmodule // png_noise_gate

// file: testbench/png_props.sv
// port checker for the playback noise gate
`timescale 1ns/1ns
module png_props import png_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic [PNG_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sample stream
   input wire logic [PNG_DW-1:0] in_left,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic [PNG_DW-1:0] out_left,
   input wire logic out_valid,
   input wire logic out_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic en_q;
   // shadow of the enable bit, valid while writes present address and data together
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) en_q <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
         s_axi_awaddr == PNG_ADDR_CTRL && s_axi_wstrb[0]) en_q <= s_axi_wdata[PNG_EN_BIT];
   end
   sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   rd_answer_a: assert property (s_rd |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   wr_answer_a: assert property (s_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write answer late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_left))
      else $error("output word lost");
   in_answer_a: assert property (in_valid && in_ready && !out_valid |=> out_valid)
      else $error("sample not forwarded");
   pass_thru_a: assert property (
      !en_q && in_valid && in_ready && !out_valid |=> out_left == $past(in_left))
      else $error("disabled gate altered data");
endmodule // png_props
bind png_noise_gate png_props i_png_props (.*);

// file: testbench/png_sink.sv
// far-side sink that stalls the gated stream at random
`timescale 1ns/1ns
module png_sink (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // stream
   input wire logic stall,
   input wire logic out_valid,
   output logic out_ready
);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) out_ready <= 1'b0;
      else out_ready <= !stall && (!out_valid || ($urandom % 3 != 0));
   end
endmodule // png_sink

// file: testbench/tb_top.sv
// self-checking bench for the playback noise gate
`timescale 1ns/1ns
module tb_top import png_pkg::*; ;
   logic clk, nrst = 0, stall = 0, in_valid = 0, out_valid, out_ready, in_ready;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1;
   logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [PNG_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, rmask = 32'hffff_ffff;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [PNG_DW-1:0] in_left = 0, in_right = 0, out_left, out_right;
   logic [PNG_AW-1:0] ad [4];
   logic [2*PNG_DW-1:0] exp_q [$];
   int num_errors = 0, cmp_count = 0, i, rdy_dly = 0;
   png_noise_gate #(.FALL_FAST_CYC(3), .FALL_SLOW_CYC(4), .RISE_SLOW_CYC(2)) i_png_noise_gate (.*);
   png_sink i_png_sink (.clk(clk), .nrst(nrst), .stall(stall), .out_valid(out_valid),
      .out_ready(out_ready));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [47:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 500) begin
         chk(0, 1, "timeout");
         conclude();
      end
   endtask
   // response ready may lag the request by rdy_dly edges, so held answers get exercised
   task automatic wr(input logic [PNG_AW-1:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      if (rdy_dly > 0) s_axi_bready <= 1'b0;
      for (n = 0; n < 500; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (n + 1 == rdy_dly) s_axi_bready <= 1'b1;
      end
      tmo(n);
      chk(s_axi_bresp, er, "bresp");
   endtask
   task automatic rd(input logic [PNG_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      if (rdy_dly > 0) s_axi_rready <= 1'b0;
      for (n = 0; n < 500; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (n + 1 == rdy_dly) s_axi_rready <= 1'b1;
      end
      tmo(n);
      chk(s_axi_rdata & rmask, ed & rmask, "rdata");
      chk(s_axi_rresp, er, "rresp");
   endtask
   task automatic snd(input logic [23:0] l, r, el, er);
      int n;
      exp_q.push_back({el, er});
      in_left <= l;
      in_right <= r;
      in_valid <= 1'b1;
      for (n = 0; n < 500; n++) begin
         @(posedge clk);
         if (in_ready) break;
      end
      tmo(n);
   endtask
   task automatic drain();
      int n;
      in_valid <= 1'b0;
      for (n = 0; n < 500; n++) begin
         @(posedge clk);
         if (exp_q.size() == 0) break;
      end
      tmo(n);
   endtask
   always @(posedge clk) begin
      if (nrst && out_valid && out_ready) begin
         if (exp_q.size() == 0) chk(0, 1, "extra word");
         else chk({out_left, out_right}, exp_q.pop_front(), "sample");
      end
   end
   initial begin
      void'($urandom(32'h5bc1));
      ad = '{PNG_ADDR_CTRL, PNG_ADDR_TIMING, PNG_ADDR_RELEASE, PNG_ADDR_ENGAGE};
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 4; i++) rd(ad[i], 0, PNG_RESP_OKAY);
      for (i = 1; i < 4; i++) begin
         v = $urandom % 8;
         wr(ad[i], v[7:0], PNG_RESP_OKAY);
         rd(ad[i], v, PNG_RESP_OKAY);
      end
      rdy_dly = 3;
      wr(PNG_ADDR_STATUS, 8'h55, PNG_RESP_OKAY);
      rd(PNG_ADDR_STATUS, 0, PNG_RESP_OKAY);
      wr(12'h300, 8'h01, PNG_RESP_SLVERR);
      rd(12'h300, 0, PNG_RESP_SLVERR);
      rdy_dly = 0;
      for (i = 0; i < 40; i++) begin
         v = $urandom;
         snd(v[23:0], ~v[23:0], v[23:0], ~v[23:0]);
      end
      drain();
      // receiver stalled: two words fill the buffer and input is refused
      stall <= 1'b1;
      snd(24'h00_1111, 24'h00_2222, 24'h00_1111, 24'h00_2222);
      snd(24'h00_3333, 24'h00_4444, 24'h00_3333, 24'h00_4444);
      in_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chk(in_ready, 0, "full");
      stall <= 1'b0;
      drain();
      wr(ad[1], 8'h00, PNG_RESP_OKAY);
      wr(ad[2], 8'h00, PNG_RESP_OKAY);
      wr(ad[3], 8'h07, PNG_RESP_OKAY);
      wr(ad[0], 8'h80, PNG_RESP_OKAY);
      // one loud word in the quiet run restarts the count
      for (i = 0; i < 456; i++) begin
         v = (i == 200) ? 32'h0000_2100 : ($urandom % 32'h0000_2000) - 32'h0000_1000;
         snd(v[23:0], v[23:0], v[23:0], v[23:0]);
      end
      drain();
      rd(PNG_ADDR_STATUS, 0, PNG_RESP_OKAY);
      snd(24'h00_0010, 24'h00_0010, 24'h00_0010, 24'h00_0010);
      drain();
      repeat (400) @(posedge clk);
      rd(PNG_ADDR_STATUS, 32'h0000_0278, PNG_RESP_OKAY);
      snd(24'h00_0010, 24'h00_0010, 0, 0);
      snd(24'h00_0100, 24'h00_0010, 0, 0);
      drain();
      repeat (300) @(posedge clk);
      rd(PNG_ADDR_STATUS, 0, PNG_RESP_OKAY);
      snd(24'h12_3456, 24'h65_4321, 24'h12_3456, 24'h65_4321);
      drain();
      // slow fall and fast rise: the state mid-ramp tells them from the other selects
      wr(ad[1], 8'h0c, PNG_RESP_OKAY);
      rd(ad[1], 32'h0000_000c, PNG_RESP_OKAY);
      for (i = 0; i < 256; i++) begin
         snd(24'h00_0010, 24'hff_fff0, 24'h00_0010, 24'hff_fff0);
      end
      drain();
      repeat (400) @(posedge clk);
      rmask = 32'h0000_0300;
      rd(PNG_ADDR_STATUS, 32'h0000_0100, PNG_RESP_OKAY);
      rmask = 32'hffff_ffff;
      repeat (100) @(posedge clk);
      rd(PNG_ADDR_STATUS, 32'h0000_0278, PNG_RESP_OKAY);
      snd(24'h00_0100, 24'h00_0010, 0, 0);
      drain();
      repeat (300) @(posedge clk);
      rmask = 32'h0000_0300;
      rd(PNG_ADDR_STATUS, 32'h0000_0300, PNG_RESP_OKAY);
      rmask = 32'hffff_ffff;
      // disabling mid-ramp snaps straight back to unity gain
      wr(ad[0], 8'h00, PNG_RESP_OKAY);
      rd(PNG_ADDR_STATUS, 0, PNG_RESP_OKAY);
      snd(24'h80_0000, 24'h7f_ffff, 24'h80_0000, 24'h7f_ffff);
      drain();
      conclude();
   end
endmodule // tb_top
